// ---- design/presence_detect_serial_slave.sv ----
`timescale 1ns/1ps
module presence_detect_serial_slave #(
   parameter int WRITE_CYCLES = pd_serial_pkg::WRITE_CYCLE_CYCLES
) (
   input  wire logic i_clock,
   input  wire logic i_reset,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda_out,
   output logic      o_sda_oe,
   input  wire logic i_addr_select_pin0,
   input  wire logic i_addr_select_pin1,
   input  wire logic i_addr_select_pin2,
   output logic      o_standby,
   output logic      o_program_busy
);
   import pd_serial_pkg::*;

   // Select byte check: type code and pin levels, shared with the checks
   function automatic logic select_matches(input logic [7:0] sel, input logic [2:0] pins);
      select_matches = (sel[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEVICE_TYPE_ID) // RQ14
                     && (sel[SEL_PIN_MSB:SEL_PIN_LSB] == pins);          // RQ16
   endfunction : select_matches

   logic       bit_val;
   logic       bit_tgl;
   logic [5:0] sync_in;
   logic [5:0] sync_out;
   logic       scl_s;
   logic       sda_s;
   logic       tgl_s;
   logic [2:0] pins_s;
   logic       scl_d;
   logic       sda_d;
   logic       tgl_d;
   logic       ev_start;
   logic       ev_stop;
   logic       ev_bit;
   logic       ev_fall;
   state_e     state;
   logic [3:0] bit_cnt;
   logic [7:0] shifter;
   logic [7:0] ptr;
   logic [7:0] store [STORE_DEPTH];
   logic [7:0] read_byte;
   logic       select_ok;
   logic       byte_end_fall;
   logic       ack_end_fall;
   logic       load_ptr;
   logic       store_we;
   logic       read_load;
   logic       wrote_pending;
   logic       program_start;

   // Link side: sample the data line on each rising clock and flag it with a toggle.
   // The sampled bit then holds for a whole clock period, so the system side may
   // read it once the toggle has crossed.
   always_ff @(posedge i_scl or posedge i_reset) begin
      if (i_reset) begin
         bit_val <= LINE_IDLE;
         bit_tgl <= 1'b0;
      end else begin
         bit_val <= i_sda;
         bit_tgl <= ~bit_tgl;
      end
   end

   // Pins and the link toggle all cross through two flops
   assign sync_in = {i_scl, i_sda, bit_tgl,
                     i_addr_select_pin2, i_addr_select_pin1, i_addr_select_pin0};

   pd_sync2 #(
      .WIDTH       (6),
      .RESET_VALUE (6'h30)
   ) u_sync (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_async (sync_in),
      .o_sync  (sync_out)
   );

   assign scl_s  = sync_out[5];
   assign sda_s  = sync_out[4];
   assign tgl_s  = sync_out[3];
   assign pins_s = sync_out[2:0];

   // Delayed copies for edge detection
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         scl_d <= LINE_IDLE;
         sda_d <= LINE_IDLE;
         tgl_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         tgl_d <= tgl_s;
      end
   end

   // Data edges with the clock high are conditions, never data
   assign ev_start = scl_s && scl_d && sda_d && !sda_s; // RQ1 RQ2
   assign ev_stop  = scl_s && scl_d && !sda_d && sda_s; // RQ1 RQ4
   assign ev_bit   = tgl_s ^ tgl_d;
   assign ev_fall  = scl_d && !scl_s;

   // A busy program cycle makes our own address look foreign
   assign select_ok     = select_matches(shifter, pins_s) && !o_program_busy; // RQ15 RQ16
   assign read_byte     = store[ptr];
   assign byte_end_fall = ev_fall && (bit_cnt == LAST_DATA_CNT);
   assign ack_end_fall  = ev_fall && (bit_cnt == ACK_DONE_CNT);
   assign load_ptr      = (state == ST_WORD_ADDR) && byte_end_fall;
   assign store_we      = (state == ST_WRITE_DATA) && byte_end_fall;
   assign read_load     = ack_end_fall
                        && (((state == ST_SELECT) && (shifter[SEL_RW_BIT] == RW_READ))
                            || (state == ST_READ_DATA));
   assign program_start = ev_stop && wrote_pending; // RQ15

   // Byte engine: start and stop override everything else on the line
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state    <= ST_STANDBY;
         bit_cnt  <= 4'h0;
         shifter  <= 8'h00;
         o_sda_oe <= 1'b0;
      end else if (ev_start) begin
         state    <= ST_SELECT; // RQ2 RQ3
         bit_cnt  <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (ev_stop) begin
         state    <= ST_STANDBY; // RQ4 RQ5
         bit_cnt  <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (ev_bit) begin
         case (state)
            ST_SELECT, ST_WORD_ADDR, ST_WRITE_DATA: begin
               if (bit_cnt < LAST_DATA_CNT) begin
                  shifter <= {shifter[6:0], bit_val}; // RQ13
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (bit_cnt == LAST_DATA_CNT) begin
                  bit_cnt <= ACK_DONE_CNT;
               end
            end
            ST_READ_DATA: begin
               // Ninth clock: a high line is the master declining more data
               if ((bit_cnt == LAST_DATA_CNT) && bit_val) begin
                  state <= ST_WAIT_STOP; // RQ12
               end
               if (bit_cnt < ACK_DONE_CNT) begin
                  bit_cnt <= bit_cnt + 4'h1; // RQ10
               end
            end
            default: begin
               bit_cnt <= bit_cnt; // RQ3
            end
         endcase
      end else if (ev_fall) begin
         case (state)
            ST_SELECT, ST_WORD_ADDR, ST_WRITE_DATA: begin
               if (bit_cnt == LAST_DATA_CNT) begin
                  if ((state == ST_SELECT) && !select_ok) begin
                     state    <= ST_STANDBY; // RQ16
                     o_sda_oe <= 1'b0;
                  end else begin
                     o_sda_oe <= 1'b1; // RQ7 RQ8 RQ9
                  end
               end else if (bit_cnt == ACK_DONE_CNT) begin
                  bit_cnt  <= 4'h0;
                  o_sda_oe <= 1'b0;
                  if (state == ST_SELECT) begin
                     if (shifter[SEL_RW_BIT] == RW_READ) begin
                        state    <= ST_READ_DATA;
                        shifter  <= read_byte;
                        o_sda_oe <= !read_byte[7]; // RQ13
                     end else begin
                        state <= ST_WORD_ADDR;
                     end
                  end else begin
                     state <= ST_WRITE_DATA; // RQ9
                  end
               end
            end
            ST_READ_DATA: begin
               if (bit_cnt == ACK_DONE_CNT) begin
                  // Acknowledged and no stop: next byte goes out at once
                  shifter  <= read_byte; // RQ11
                  o_sda_oe <= !read_byte[7];
                  bit_cnt  <= 4'h0;
               end else if (bit_cnt == LAST_DATA_CNT) begin
                  o_sda_oe <= 1'b0; // RQ6 RQ10
               end else begin
                  shifter  <= {shifter[6:0], 1'b0};
                  o_sda_oe <= !shifter[6]; // RQ13
               end
            end
            default: begin
               o_sda_oe <= 1'b0; // RQ12
            end
         endcase
      end
   end

   // Byte pointer: loaded by the word address, advanced by each byte moved
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         ptr <= PTR_RESET;
      end else if (load_ptr) begin
         ptr <= shifter;
      end else if (store_we || read_load) begin
         ptr <= ptr + 8'h01;
      end
   end

   // Storage array; cleared at reset so reads never return unknowns
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < STORE_DEPTH; i++) begin
            store[i] <= STORE_RESET;
         end
      end else if (store_we) begin
         store[ptr] <= shifter;
      end
   end

   // Remember that data was written so the closing stop starts programming
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         wrote_pending <= 1'b0;
      end else if (store_we) begin
         wrote_pending <= 1'b1;
      end else if (ev_stop) begin
         wrote_pending <= 1'b0;
      end
   end

   pd_program_timer #(
      .CYCLES (WRITE_CYCLES)
   ) u_program (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_start (program_start),
      .o_busy  (o_program_busy)
   );

   // Open drain: the driven level is always low, the enable carries the data
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_sda_out <= SDA_DRIVE_LEVEL;
      end else begin
         o_sda_out <= SDA_DRIVE_LEVEL;
      end
   end

   // Standby indication lags the state by one cycle
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_standby <= 1'b1;
      end else begin
         o_standby <= (state == ST_STANDBY);
      end
   end

   chk_drive_on_fall: assert property (@(posedge i_clock) disable iff (i_reset) // RQ1
      $changed(o_sda_oe) |-> $past(ev_fall) || $past(ev_start) || $past(ev_stop))
      else $error("data line changed outside a clock low phase");

   chk_start_select: assert property (@(posedge i_clock) disable iff (i_reset) // RQ2
      ev_start |=> (state == ST_SELECT) && (bit_cnt == 4'h0) && !o_sda_oe)
      else $error("start did not open a select byte");

   chk_standby_quiet: assert property (@(posedge i_clock) disable iff (i_reset) // RQ3
      (state == ST_STANDBY) && !ev_start |=> (state == ST_STANDBY) && !o_sda_oe)
      else $error("slave left standby without a start");

   chk_stop_standby: assert property (@(posedge i_clock) disable iff (i_reset) // RQ5
      ev_stop |=> (state == ST_STANDBY) ##1 o_standby)
      else $error("stop did not return to standby");

   chk_ack_match: assert property (@(posedge i_clock) disable iff (i_reset) // RQ8
      (state == ST_SELECT) && byte_end_fall && select_matches(shifter, pins_s)
      && !o_program_busy |=> o_sda_oe ##1 (o_sda_oe && state == ST_SELECT))
      else $error("matching select byte not acknowledged");

   chk_mismatch_silent: assert property (@(posedge i_clock) disable iff (i_reset) // RQ16
      (state == ST_SELECT) && byte_end_fall && !select_matches(shifter, pins_s)
      |=> !o_sda_oe && (state == ST_STANDBY))
      else $error("foreign select byte answered");

   chk_write_ack: assert property (@(posedge i_clock) disable iff (i_reset) // RQ9
      (state == ST_WRITE_DATA) && byte_end_fall |=> o_sda_oe)
      else $error("written byte not acknowledged");

   chk_read_release: assert property (@(posedge i_clock) disable iff (i_reset) // RQ10
      (state == ST_READ_DATA) && byte_end_fall |=> !o_sda_oe)
      else $error("line not released for master acknowledge");

   chk_read_continue: assert property (@(posedge i_clock) disable iff (i_reset) // RQ11
      (state == ST_READ_DATA) && ev_bit && (bit_cnt == LAST_DATA_CNT) && !bit_val
      |=> (state == ST_READ_DATA) && (bit_cnt == ACK_DONE_CNT))
      else $error("acknowledged read did not continue");

   chk_nack_wait: assert property (@(posedge i_clock) disable iff (i_reset) // RQ12
      (state == ST_READ_DATA) && ev_bit && (bit_cnt == LAST_DATA_CNT) && bit_val
      |=> (state == ST_WAIT_STOP))
      else $error("unacknowledged read kept sending");

   // Own select byte seen while programming must be refused and left unanswered
   chk_busy_silent: assert property (@(posedge i_clock) disable iff (i_reset) // RQ15
      o_program_busy && (state == ST_SELECT) && byte_end_fall
      |=> !o_sda_oe && (state == ST_STANDBY))
      else $error("slave active during program cycle");
endmodule : presence_detect_serial_slave

// ---- include/pd_serial_pkg.sv ----
// Functional notes
// RQ1 - Data line changes only while clock low; changes during clock high mean start/stop.
// RQ2 - Start is data falling while clock high; it precedes every command.
// RQ3 - Slave watches both lines and ignores everything until a valid start.
// RQ4 - Stop is data rising while clock high; it ends every transaction.
// RQ5 - On stop the slave enters standby and idles until the next start.
// RQ6 - After each eight-bit byte the transmitter releases the data line.
// RQ7 - During the ninth clock the receiver holds data low to acknowledge.
// RQ8 - Slave acknowledges after a start followed by its own matching select byte.
// RQ9 - When addressed for write, slave acknowledges every later byte until stop.
// RQ10 - In read mode slave sends eight bits, releases, samples master acknowledge.
// RQ11 - Master acknowledge without stop makes the slave send the next byte.
// RQ12 - Master no-acknowledge: slave stops driving, awaits stop, returns to standby.
// RQ13 - Every byte, select byte included, travels most significant bit first.
// RQ14 - Select byte: type 1010 in bits 7-4, pin levels 3-1, direction bit 0 (1=read).
// RQ15 - For up to 10 ms after a write stop: program, stay released, ignore address.
// RQ16 - Select bits 3-1 are compared with the pin levels; mismatch stays silent.
package pd_serial_pkg;

   // Select byte layout
   localparam logic [3:0] DEVICE_TYPE_ID  = 4'hA;
   localparam int         SEL_TYPE_MSB    = 7;
   localparam int         SEL_TYPE_LSB    = 4;
   localparam int         SEL_PIN_MSB     = 3;
   localparam int         SEL_PIN_LSB     = 1;
   localparam int         SEL_RW_BIT      = 0;
   localparam logic       RW_READ         = 1'b1;

   // Rising clock counts within one byte frame
   localparam logic [3:0] LAST_DATA_CNT   = 4'h8;
   localparam logic [3:0] ACK_DONE_CNT    = 4'h9;

   // Storage
   localparam int         STORE_DEPTH     = 256;
   localparam logic [7:0] STORE_RESET     = 8'h00;
   localparam logic [7:0] PTR_RESET       = 8'h00;

   // Line levels
   localparam logic       SDA_DRIVE_LEVEL = 1'b0;
   localparam logic       LINE_IDLE       = 1'b1;

   // Program cycle timing
   localparam int         CLOCK_HZ           = 100000000;
   localparam int         WRITE_CYCLE_MS     = 10;
   localparam int         WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * (CLOCK_HZ / 1000);

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_SELECT,
      ST_WORD_ADDR,
      ST_WRITE_DATA,
      ST_READ_DATA,
      ST_WAIT_STOP
   } state_e;

endpackage : pd_serial_pkg

// ---- design/pd_sync2.sv ----
`timescale 1ns/1ps
module pd_sync2 #(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             i_clock,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1;

   // Two flops; only the second stage is visible outside
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         stage1 <= RESET_VALUE;
         o_sync <= RESET_VALUE;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule : pd_sync2

// ---- design/pd_program_timer.sv ----
`timescale 1ns/1ps
module pd_program_timer #(
   parameter int CYCLES = 1000
) (
   input  wire logic i_clock,
   input  wire logic i_reset,
   input  wire logic i_start,
   output logic      o_busy
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] remaining;
   logic [CW-1:0] next_remaining;

   // Restart reloads the full span; otherwise count down to idle
   always_comb begin
      next_remaining = remaining;
      if (i_start) begin
         next_remaining = CW'(CYCLES);
      end else if (remaining != '0) begin
         next_remaining = remaining - 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         remaining <= '0;
      end else begin
         remaining <= next_remaining;
      end
   end

   // Busy registered from the next count so it rises right after the start
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= (next_remaining != '0);
      end
   end

   chk_busy_holds: assert property (@(posedge i_clock) disable iff (i_reset) // RQ15
      $rose(o_busy) |-> o_busy [*8])
      else $error("program busy dropped too early");

   chk_busy_ends: assert property (@(posedge i_clock) disable iff (i_reset) // RQ15
      (remaining == CW'(1)) && !i_start |=> !o_busy)
      else $error("program busy outlived its count");
endmodule : pd_program_timer

// ---- sim/two_wire_master.sv ----
`timescale 1ns/1ps
// Bus master model: owns the serial clock, which stands high between frames
module two_wire_master (
   output logic      o_scl,
   output logic      o_sda_oe,
   input  wire logic i_sda
);
   localparam realtime HALF  = 62.5;
   localparam realtime SETUP = 20.0;

   // Idle bus at time zero
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end

   // One clock; data moves well inside the low phase, sampled at the rise
   task automatic put_bit(input logic v, output logic s);
      #(SETUP) o_sda_oe = ~v;
      #(HALF - SETUP) o_scl = 1'b1;
      s = i_sda;
      #(HALF) o_scl = 1'b0;
   endtask : put_bit

   // Start from idle, or a repeated start from clock low
   task automatic start();
      if (o_scl === 1'b0) begin
         #(SETUP) o_sda_oe = 1'b0;
         #(HALF - SETUP) o_scl = 1'b1;
      end
      #(HALF) o_sda_oe = 1'b1;
      #(HALF) o_scl = 1'b0;
   endtask : start

   // Stop ends every frame; the clock then stands high
   task automatic stop();
      #(SETUP) o_sda_oe = 1'b1;
      #(HALF - SETUP) o_scl = 1'b1;
      #(HALF) o_sda_oe = 1'b0;
      #(HALF);
   endtask : stop

   // Clock falls with data high: neither start nor stop
   task automatic clock_low();
      #(HALF) o_scl = 1'b0;
   endtask : clock_low

   // Byte out, most significant bit first, then released for the ack
   task automatic send_byte(input logic [7:0] b, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      acked = (s === 1'b0);
   endtask : send_byte

   // Byte in; a low ninth bit asks for more, a released one ends the read
   task automatic recv_byte(input logic ack, output logic [7:0] b, output logic ninth);
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, b[i]);
      end
      put_bit(~ack, ninth);
   endtask : recv_byte
endmodule : two_wire_master

// ---- sim/presence_detect_serial_slave_tb.sv ----
`timescale 1ns/1ps
module presence_detect_serial_slave_tb;
   import pd_serial_pkg::*;
   localparam int         WRITE_CYCLES = 400;
   localparam logic [2:0] PINS         = 3'h5;

   logic       i_clock;
   logic       i_reset;
   logic       scl;
   logic       m_oe;
   logic       sda_line;
   logic       o_sda_out;
   logic       o_sda_oe;
   logic       o_standby;
   logic       o_program_busy;
   logic [2:0] pins;
   logic       ack;
   logic       ninth;
   logic [7:0] d;
   int         busy_len;
   int         bad_count;
   int         check_count;

   // Open-drain wire with pull-up; the slave pulls low only if its level is low
   assign sda_line = ~(m_oe | (o_sda_oe & ~o_sda_out));

   presence_detect_serial_slave #(.WRITE_CYCLES(WRITE_CYCLES)) presence_detect_serial_slave_inst (
      .i_clock            (i_clock),
      .i_reset            (i_reset),
      .i_scl              (scl),
      .i_sda              (sda_line),
      .o_sda_out          (o_sda_out),
      .o_sda_oe           (o_sda_oe),
      .i_addr_select_pin0 (pins[0]),
      .i_addr_select_pin1 (pins[1]),
      .i_addr_select_pin2 (pins[2]),
      .o_standby          (o_standby),
      .o_program_busy     (o_program_busy)
   );

   two_wire_master two_wire_master_inst (
      .o_scl    (scl),
      .o_sda_oe (m_oe),
      .i_sda    (sda_line)
   );

   // System clock
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // Length of each program cycle, in system clocks
   always @(posedge i_clock) begin
      if (o_program_busy === 1'b1) begin
         busy_len <= busy_len + 1;
      end
   end

   // The slave may only move the data line while the clock is low
   always @(o_sda_oe) begin
      if ($time > 0 && i_reset === 1'b0 && scl === 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: slave data moved with clock high", $time);
      end
   end

   function automatic logic [7:0] sel(input logic [2:0] p, input logic rw);
      return {DEVICE_TYPE_ID, p, rw};
   endfunction : sel

   task automatic expect_eq(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : expect_eq

   // Small offset keeps every later link edge off the system clock edges
   task automatic settle();
      repeat (8) @(posedge i_clock);
      @(negedge i_clock);
      #2;
   endtask : settle

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // Outputs during and just after reset
   task automatic t_reset();
      expect_eq(o_sda_oe, 1'b0, "oe in reset");
      expect_eq(o_standby, 1'b1, "standby in reset");
      expect_eq(o_sda_out, 1'b0, "drive level in reset");
      @(negedge i_clock) i_reset = 1'b0;
      expect_eq(o_program_busy, 1'b0, "busy after reset");
      settle();
   endtask : t_reset

   // A full select byte with no start before it draws no answer
   task automatic t_no_start();
      two_wire_master_inst.clock_low();
      two_wire_master_inst.send_byte(sel(PINS, 1'b0), ack);
      expect_eq(ack, 1'b0, "ack without start");
      expect_eq(o_standby, 1'b1, "standby without start");
      two_wire_master_inst.stop();
      settle();
   endtask : t_no_start

   // Write two bytes, then probe the slave while it programs
   task automatic t_write();
      two_wire_master_inst.start();
      two_wire_master_inst.send_byte(sel(PINS, 1'b0), ack);
      expect_eq(ack, 1'b1, "write select ack");
      expect_eq(o_standby, 1'b0, "awake after start");
      two_wire_master_inst.send_byte(8'h10, ack);
      expect_eq(ack, 1'b1, "address ack");
      two_wire_master_inst.send_byte(8'h5A, ack);
      expect_eq(ack, 1'b1, "data ack 1");
      two_wire_master_inst.send_byte(8'hC3, ack);
      expect_eq(ack, 1'b1, "data ack 2");
      busy_len = 0;
      two_wire_master_inst.stop();
      settle();
      expect_eq(o_standby, 1'b1, "standby after stop");
      expect_eq(o_program_busy, 1'b1, "program cycle running");
      two_wire_master_inst.start();
      two_wire_master_inst.send_byte(sel(PINS, 1'b1), ack);
      expect_eq(ack, 1'b0, "select while programming");
      two_wire_master_inst.stop();
      for (int n = 0; n < 600 && o_program_busy !== 1'b0; n++) begin
         @(negedge i_clock);
      end
      expect_eq(busy_len >= WRITE_CYCLES - 1 && busy_len <= WRITE_CYCLES + 1, 1'b1,
                "program cycle length");
      settle();
   endtask : t_write

   // Wrong pin levels and a wrong type code stay silent; pins then move
   task automatic t_bad_select();
      logic [7:0] codes [4];
      codes = '{sel(PINS ^ 3'h1, 1'b0), sel(PINS ^ 3'h2, 1'b1), sel(PINS ^ 3'h4, 1'b0),
                {4'h6, PINS, 1'b0}};
      foreach (codes[k]) begin
         two_wire_master_inst.start();
         two_wire_master_inst.send_byte(codes[k], ack);
         expect_eq(ack, 1'b0, "foreign select");
         two_wire_master_inst.stop();
      end
      @(negedge i_clock);
      pins = 3'h2;
      settle();
      two_wire_master_inst.start();
      two_wire_master_inst.send_byte(sel(3'h2, 1'b1), ack);
      expect_eq(ack, 1'b1, "select after pin change");
      two_wire_master_inst.recv_byte(1'b0, d, ninth);
      expect_eq(d, 8'h00, "current address read");
      expect_eq(o_sda_out, 1'b0, "open-drain level");
      two_wire_master_inst.stop();
      @(negedge i_clock);
      pins = PINS;
      settle();
   endtask : t_bad_select

   // Random read: set pointer, restart, read on with ack, end with no-ack
   task automatic t_read();
      two_wire_master_inst.start();
      two_wire_master_inst.send_byte(sel(PINS, 1'b0), ack);
      two_wire_master_inst.send_byte(8'h10, ack);
      two_wire_master_inst.start();
      two_wire_master_inst.send_byte(sel(PINS, 1'b1), ack);
      expect_eq(ack, 1'b1, "read select ack");
      two_wire_master_inst.recv_byte(1'b1, d, ninth);
      expect_eq(d, 8'h5A, "first read byte");
      two_wire_master_inst.recv_byte(1'b0, d, ninth);
      expect_eq(d, 8'hC3, "second read byte");
      expect_eq(ninth, 1'b1, "released on ninth clock");
      two_wire_master_inst.recv_byte(1'b0, d, ninth);
      expect_eq(d, 8'hFF, "silent after no-ack");
      two_wire_master_inst.stop();
      settle();
      expect_eq(o_standby, 1'b1, "standby after read");
      expect_eq(o_program_busy, 1'b0, "no program after read");
   endtask : t_read

   // Hang guard, well beyond the expected few tens of microseconds
   initial begin
      #300000;
      bad_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end

   // Main sequence
   initial begin
      bad_count   = 0;
      check_count = 0;
      busy_len    = 0;
      i_reset     = 1'b1;
      pins        = PINS;
      repeat (6) @(posedge i_clock);
      t_reset();
      t_no_start();
      t_write();
      t_bad_select();
      t_read();
      results();
   end
endmodule : presence_detect_serial_slave_tb
